// >>> include/mpcu_pkg.sv
// Purpose: Constants and types for the multipurpose compare unit
// Assumes: Single system clock, asynchronous active-high reset
// Notes: Commands arrive as an 8-bit code with two 16-bit data words (low and high)
// Behaviour
// [R1] Four compare registers, modes set together
// [R2] Host loads mode word, then command 20h
// [R3] Mode readback command returns stored mode word
// [R4] Quantity field: logical, real, speed, timer
// [R5] Condition field: ge, gt, eq, lt
// [R6] Register k uses mode bits 4k+3..4k
// [R7] Output high while condition holds, else low
// [R8] Results drive shared pins four to seven
// [R9] Host selects compare function via pin command
// [R10] Unselected pins keep alternative functions
// [R11] Rising result fires sync set and interrupt
// [R12] Host avoids equality on fast speed ramps
// [R13] Signed 32-bit registers, read and write anytime
// [R14] Already-true result at enable does not fire
// [R15] Interrupt enable and status bits D3..D0
// [R16] Compare every clock with signed arithmetic
// [R17] Mode write effective next clock, held
`default_nettype none
package mpcu_pkg;
	localparam int NREG = 4;
	localparam int DW   = 32;
	localparam int MW   = 16;
	localparam logic [7:0] CMD_SET_REG0 = 8'h10;
	localparam logic [7:0] CMD_SET_MODE = 8'h20;
	localparam logic [7:0] CMD_SET_PIN1 = 8'h21;
	localparam logic [7:0] CMD_RD_REG0  = 8'h34;
	localparam logic [7:0] CMD_RD_MODE  = 8'h40;
	localparam logic [1:0] Q_LOGICAL = 2'h0;
	localparam logic [1:0] Q_REAL    = 2'h1;
	localparam logic [1:0] Q_SPEED   = 2'h2;
	localparam logic [1:0] Q_TIMER   = 2'h3;
	localparam logic [1:0] C_GE = 2'h0;
	localparam logic [1:0] C_GT = 2'h1;
	localparam logic [1:0] C_EQ = 2'h2;
	localparam logic [1:0] C_LT = 2'h3;
	localparam logic [1:0] PIN_CMP_SEL = 2'h3;
	localparam int PIN_FIELD_LSB = 8;
	localparam int PIN_FIELD_W   = 2;
	localparam int MODE_FIELD_W  = 4;
	localparam logic signed [DW-1:0] REG_RESET = 32'sh0000_0000;
	localparam logic [MW-1:0] MODE_RESET = 16'h0000;
	localparam logic [MW-1:0] PIN_RESET  = 16'h0000;
	typedef struct packed {
		logic [1:0] cond;
		logic [1:0] qsel;
	} mpcu_mode_s;
	typedef struct packed {
		logic signed [DW-1:0] logical_position_count;
		logic signed [DW-1:0] real_position_count;
		logic signed [DW-1:0] current_drive_speed;
		logic signed [DW-1:0] current_timer_value;
	} mpcu_qty_s;
endpackage
`default_nettype wire

// >>> rtl/mpcu_compare_unit.sv
// Purpose: Four compare registers checked against axis quantities
// Assumes: Command strobe is a one-cycle pulse on the system clock
// Notes: Results feed shared pins, sync sets and interrupt flags
`timescale 1ns/1ns
`default_nettype none
module mpcu_compare_unit
	import mpcu_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  cmd_valid,
	input  wire logic [7:0]            cmd_code,
	input  wire logic [MW-1:0]         data_write_low,
	input  wire logic [MW-1:0]         data_write_high,
	input  wire mpcu_qty_s             qty,
	input  wire logic [NREG-1:0]       interrupt_mode_bits,
	input  wire logic [NREG-1:0]       sync_enable,
	input  wire logic [NREG-1:0]       irq_status_clear,
	input  wire logic [NREG-1:0]       alt_pin_out,
	input  wire logic [NREG-1:0]       alt_pin_oe,
	output var  logic [DW-1:0]         read_data,
	output var  logic                  read_valid,
	output var  logic [NREG-1:0]       compare_result,
	output var  logic [NREG-1:0]       shared_compare_pins_out,
	output var  logic [NREG-1:0]       shared_compare_pins_oe,
	output var  logic [NREG-1:0]       sync_action_sets,
	output var  logic [NREG-1:0]       interrupt_status_register,
	output var  logic                  irq
);
	logic [MW-1:0]        compare_mode_word_reg;
	logic [MW-1:0]        pin_setting_reg;
	logic signed [DW-1:0] general_compare_registers [NREG];
	logic [NREG-1:0]      cmp_now;
	logic [NREG-1:0]      armed_sync_reg;
	logic [NREG-1:0]      armed_irq_reg;
	logic [NREG-1:0]      rise;
	logic [NREG-1:0]      pin_sel;

	// [R2] Mode word taken from data register on command
	// [R17] Stored next clock, held until rewritten
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_mode_word_reg <= MODE_RESET;
		end else if (cmd_valid && cmd_code == CMD_SET_MODE) begin
			compare_mode_word_reg <= data_write_low;
		end
	end

	// [R10] Pin function selection register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_setting_reg <= PIN_RESET;
		end else if (cmd_valid && cmd_code == CMD_SET_PIN1) begin
			pin_setting_reg <= data_write_low;
		end
	end

	// [R1] Four registers, one mode command
	genvar k;
	generate
		for (k = 0; k < NREG; k++) begin : g_cmp
			mpcu_mode_s           m;
			logic signed [DW-1:0] q;
			logic                 c;
			// [R6] Per-register mode field slice
			assign m = compare_mode_word_reg[MODE_FIELD_W*k +: MODE_FIELD_W];
			// [R13] Compare register written by set command
			// Reset value only keeps results defined
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					general_compare_registers[k] <= REG_RESET;
				end else if (cmd_valid &&
					cmd_code == CMD_SET_REG0 + 8'(k)) begin
					general_compare_registers[k] <=
						{data_write_high, data_write_low};
				end
			end
			// [R4] Quantity selection
			always_comb begin
				unique case (m.qsel)
					Q_LOGICAL: q = qty.logical_position_count;
					Q_REAL:    q = qty.real_position_count;
					Q_SPEED:   q = qty.current_drive_speed;
					Q_TIMER:   q = qty.current_timer_value;
				endcase
			end
			// [R5] Condition, signed every cycle
			// [R16] Continuous signed evaluation
			always_comb begin
				unique case (m.cond)
					C_GE: c = q >= general_compare_registers[k];
					C_GT: c = q >  general_compare_registers[k];
					C_EQ: c = q == general_compare_registers[k];
					C_LT: c = q <  general_compare_registers[k];
				endcase
			end
			assign cmp_now[k] = c;
			// [R9] Pin field 1,1 selects compare output
			assign pin_sel[k] = pin_setting_reg[PIN_FIELD_LSB +
				PIN_FIELD_W*k +: PIN_FIELD_W] == PIN_CMP_SEL;
		end
	endgenerate

	// [R7] Result registered high while condition holds
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			compare_result <= '0;
		end else begin
			compare_result <= cmp_now;
		end
	end

	// [R8] Results to pins four to seven
	// [R10] Alternative function kept when not selected
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shared_compare_pins_out <= '0;
			shared_compare_pins_oe  <= '0;
		end else begin
			shared_compare_pins_out <=
				(pin_sel & cmp_now) | (~pin_sel & alt_pin_out);
			shared_compare_pins_oe <= pin_sel | alt_pin_oe;
		end
	end

	assign rise = cmp_now & ~compare_result;

	// [R14] Arm only after a false result while enabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_sync_reg <= '0;
			armed_irq_reg  <= '0;
		end else begin
			armed_sync_reg <= sync_enable &
				(armed_sync_reg | ~cmp_now);
			armed_irq_reg  <= interrupt_mode_bits &
				(armed_irq_reg | ~cmp_now);
		end
	end

	// [R11] Sync set pulse on false-to-true
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_action_sets <= '0;
		end else begin
			sync_action_sets <= rise & armed_sync_reg;
		end
	end

	// [R15] Sticky cause bits, set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interrupt_status_register <= '0;
			irq                       <= 1'b0;
		end else begin
			interrupt_status_register <= (interrupt_status_register &
				~irq_status_clear) | (rise & armed_irq_reg);
			irq <= |((interrupt_status_register & ~irq_status_clear) |
				(rise & armed_irq_reg));
		end
	end

	// [R3] Readback of mode word and registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			read_data  <= '0;
			read_valid <= 1'b0;
		end else begin
			read_valid <= 1'b0;
			if (cmd_valid && cmd_code == CMD_RD_MODE) begin
				read_data  <= {{(DW-MW){1'b0}}, compare_mode_word_reg};
				read_valid <= 1'b1;
			end else if (cmd_valid && cmd_code >= CMD_RD_REG0 &&
				cmd_code < CMD_RD_REG0 + 8'(NREG)) begin
				read_data  <= general_compare_registers[
					cmd_code[1:0] - 2'(CMD_RD_REG0)];
				read_valid <= 1'b1;
			end
		end
	end

	// [R17] Mode word follows a set command by one clock
	chk_mode_write_take: assert property ( // [R17]
		@(posedge clk) disable iff (rst)
		cmd_valid && cmd_code == CMD_SET_MODE |=>
		compare_mode_word_reg == $past(data_write_low))
		else $error("mode word not stored");
	// [R17] Mode held without command
	chk_mode_hold_idle: assert property ( // [R17]
		@(posedge clk) disable iff (rst)
		!(cmd_valid && cmd_code == CMD_SET_MODE) |=>
		$stable(compare_mode_word_reg))
		else $error("mode word changed");
	// [R3] Readback returns mode word
	chk_mode_read_back: assert property ( // [R3]
		@(posedge clk) disable iff (rst)
		cmd_valid && cmd_code == CMD_RD_MODE |=> read_valid &&
		read_data[MW-1:0] == $past(compare_mode_word_reg))
		else $error("mode readback wrong");
	// [R7] Result follows condition by one clock
	chk_result_follow: assert property ( // [R7]
		@(posedge clk) disable iff (rst)
		1'b1 |=> compare_result == $past(cmp_now))
		else $error("result mismatch");
	// [R8] Selected pin carries result
	chk_pin_carries: assert property ( // [R8]
		@(posedge clk) disable iff (rst)
		pin_sel[0] |=> shared_compare_pins_oe[0] &&
		shared_compare_pins_out[0] == compare_result[0])
		else $error("pin not carrying result");
	// [R10] Unselected pin keeps its alternative
	chk_pin_alt_keep: assert property ( // [R10]
		@(posedge clk) disable iff (rst)
		!pin_sel[1] |=>
		shared_compare_pins_out[1] == $past(alt_pin_out[1]) &&
		shared_compare_pins_oe[1] == $past(alt_pin_oe[1]))
		else $error("pin lost alternative function");
	// [R11] Sync pulse only on a rising result
	chk_sync_on_rise: assert property ( // [R11]
		@(posedge clk) disable iff (rst)
		sync_action_sets[1] |-> compare_result[1] &&
		!$past(compare_result[1]))
		else $error("sync without rise");
	// [R14] No firing while enable is off
	sequence seq_irq2_off;
		!interrupt_mode_bits[2] ##1 !interrupt_mode_bits[2];
	endsequence
	chk_no_arm_fire: assert property ( // [R14]
		@(posedge clk) disable iff (rst)
		seq_irq2_off |=> !$rose(interrupt_status_register[2]))
		else $error("interrupt fired while disabled");
	// [R15] Armed rise always sets its cause bit
	chk_status_set_wins: assert property ( // [R15]
		@(posedge clk) disable iff (rst)
		rise[0] && armed_irq_reg[0] |=> interrupt_status_register[0])
		else $error("interrupt cause lost");
	// [R15] Irq reflects status bits
	chk_irq_status: assert property ( // [R15]
		@(posedge clk) disable iff (rst)
		irq == |interrupt_status_register)
		else $error("irq not matching status");
endmodule // mpcu_compare_unit
`default_nettype wire

// >>> testbench/mpcu_host_model.sv
// Purpose: Host side that issues commands to the compare unit
// Assumes: Commands launch just after a rising clock edge
// Notes: Data lines invert once released, they are not held
`timescale 1ns/1ns
`default_nettype none
module mpcu_host_model
	import mpcu_pkg::*;
(
	input  wire logic          clk,
	output var  logic          cmd_valid,
	output var  logic [7:0]    cmd_code,
	output var  logic [MW-1:0] data_write_low,
	output var  logic [MW-1:0] data_write_high
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		{data_write_high, data_write_low} = 32'h0000_0000;
	end
	task automatic send(input logic [7:0] code, input logic [31:0] d);
		@(posedge clk);
		#1;
		{data_write_high, data_write_low} = d;
		cmd_code = code;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		{data_write_high, data_write_low} = ~d;
	endtask
endmodule // mpcu_host_model
`default_nettype wire

// >>> testbench/multipurpose_compare_unit_tb.sv
// Purpose: Self-checking bench for the multipurpose compare unit
// Assumes: Host model issues every command
// Notes: Compare registers are written before results are used
`timescale 1ns/1ns
`default_nettype none
module multipurpose_compare_unit_tb
	import mpcu_pkg::*;
;
	logic                 clk, rst, cmd_valid, rvalid, irq;
	logic [7:0]           cmd_code;
	logic [MW-1:0]        dwl, dwh, m;
	mpcu_qty_s            qty;
	logic [NREG-1:0]      imb, sen, clr, apo, aoe, res, po, poe, sync, stat, e;
	logic [DW-1:0]        rdata;
	logic signed [DW-1:0] qv [4];
	int                   errors, compares;
	mpcu_host_model host (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .data_write_low(dwl), .data_write_high(dwh));
	mpcu_compare_unit DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .data_write_low(dwl), .data_write_high(dwh),
		.qty(qty), .interrupt_mode_bits(imb), .sync_enable(sen),
		.irq_status_clear(clr), .alt_pin_out(apo), .alt_pin_oe(aoe),
		.read_data(rdata), .read_valid(rvalid), .compare_result(res),
		.shared_compare_pins_out(po), .shared_compare_pins_oe(poe),
		.sync_action_sets(sync), .interrupt_status_register(stat), .irq(irq));
	task automatic summarize();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(string n, logic [DW-1:0] x, logic [DW-1:0] g);
		compares++;
		if (x !== g) begin
			errors++;
			$display("unexpected %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rd(logic [7:0] c, logic [DW-1:0] x, string n);
		int i;
		host.send(c, 32'h0000_0000);
		for (i = 0; i < 4 && rvalid !== 1'b1; i++)
			wt(1);
		if (i == 4) begin
			errors++;
			summarize();
		end else
			chk(n, x, rdata);
	endtask
	function automatic logic cmpf(logic [1:0] c, logic signed [DW-1:0] q, r);
		case (c)
			C_GE: return q >= r;
			C_GT: return q > r;
			C_EQ: return q == r;
			default: return q < r;
		endcase
	endfunction
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{imb, sen, clr} = 12'h000;
		apo = 4'hA;
		aoe = 4'h5;
		qv = '{-3, -1, 0, 5};
		qty = {qv[0], qv[1], qv[2], qv[3]};
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int k = 0; k < 4; k++)
			host.send(8'(CMD_SET_REG0 + k), DW'(k - 2));
		for (int k = 0; k < 4; k++)
			rd(8'(CMD_RD_REG0 + k), DW'(k - 2), "reg");
		$display("test registers done");
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 4; k++) begin
				m[4*k +: 4] = {2'(c), 2'((k + c) % 4)};
				e[k] = cmpf(2'(c), qv[(k + c) % 4], DW'(k - 2));
			end
			host.send(CMD_SET_MODE, {16'h0000, m});
			wt(3);
			chk("result", e, res);
			rd(CMD_RD_MODE, {16'h0000, m}, "mode");
		end
		$display("test compare done");
		chk("pins alt", {apo, aoe}, {po, poe});
		host.send(CMD_SET_PIN1, 32'h0000_C300);
		wt(3);
		chk("pins", {e[3], apo[2:1], e[0], 4'h9 | aoe}, {po, poe});
		$display("test pins done");
		host.send(CMD_SET_MODE, 32'h0000_0000);
		qty.logical_position_count = 32'sd5;
		wt(3);
		imb = 4'h1;
		sen = 4'h1;
		wt(3);
		chk("armed", 8'h00, {sync, stat});
		qty.logical_position_count = -32'sd3;
		wt(3);
		qty.logical_position_count = 32'sd5;
		wt(1);
		chk("sync", 4'h1, sync);
		wt(1);
		chk("status", 5'h11, {irq, stat});
		clr = 4'h1;
		wt(1);
		clr = 4'h0;
		wt(1);
		chk("clear", 5'h00, {irq, stat});
		$display("test interrupt done");
		rst = 1'b1;
		wt(2);
		rst = 1'b0;
		rd(CMD_RD_MODE, 32'h0000_0000, "mode reset");
		chk("reset fire", 5'h00, {irq, stat});
		$display("test reset done");
		summarize();
	end
endmodule // multipurpose_compare_unit_tb
`default_nettype wire
